// ===== alu_bit_ops_pkg.sv
// alu_bit_ops_pkg: widths, reset values, operation codes and states of the
// accumulator / bit-operation execute stage.
// assumes the decoder and the register file share these codes and widths.
package alu_bit_ops_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int BIT_W = 3;
   localparam int NIBBLE_W = 4;

   ////////////////////////////////////////////////////////////////////////////
   // reset values and the single-bit mask base
   localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
   localparam logic FLAG_RST = 1'b0;
   localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;

   // destination select values for byte-oriented file operations
   localparam logic DEST_ACCUM = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // operations carried out by this stage
   typedef enum logic [2:0] {
      add_immediate_to_accum = 3'h0,
      add_accum_with_file = 3'h1,
      and_immediate_into_accum = 3'h2,
      and_accum_with_file = 3'h3,
      file_bit_clear = 3'h4,
      file_bit_set = 3'h5,
      test_skip_if_zero_bit = 3'h6,
      test_skip_if_one_bit = 3'h7
   } op_t;

   // execute state, one-hot
   typedef enum logic [1:0] {
      ST_EXEC = 2'b01,
      ST_SKIP = 2'b10
   } state_t;

endpackage

// ===== alu_bit_ops_exec.sv
// alu_bit_ops_exec: execute stage for add, and, bit set/clear and
// bit-test-and-skip operations of an 8-bit core.
// assumes the register file answers FILE_RDATA combinationally for
// OP_FILE_ADDR in the same cycle, and takes FILE_WE/ADDR/WDATA one cycle later.
`timescale 1ns/1ps
`default_nettype none

module alu_bit_ops_exec
   import alu_bit_ops_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic OP_VALID,
   output logic OP_READY,
   input wire op_t OP_CODE,
   input wire logic [DATA_W-1:0] OP_IMM,
   input wire logic [ADDR_W-1:0] OP_FILE_ADDR,
   input wire logic [BIT_W-1:0] OP_BIT_SEL,
   input wire logic OP_DEST,
   input wire logic [DATA_W-1:0] FILE_RDATA,
   input wire logic FILE_IS_PORT,
   input wire logic [DATA_W-1:0] PIN_LEVELS,
   input wire logic FILE_IS_TIMER,
   input wire logic PRESCALER_ON_TIMER,
   output logic FILE_WE,
   output logic [ADDR_W-1:0] FILE_WADDR,
   output logic [DATA_W-1:0] FILE_WDATA,
   output logic [DATA_W-1:0] ACCUM,
   output logic CARRY,
   output logic NIBBLE_CARRY,
   output logic ZERO,
   output logic SKIPPING,
   output logic PRESCALER_CLR
);

   ////////////////////////////////////////////////////////////////////////////
   // reset release: asynchronous assert, two-flop synchronous release
   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser; only the second stage is read by logic
   logic [DATA_W-1:0] pin_meta_reg;
   logic [DATA_W-1:0] pin_sync_reg;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_reg <= ACCUM_RST;
         pin_sync_reg <= ACCUM_RST;
      end else begin
         pin_meta_reg <= PIN_LEVELS;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operand selection and arithmetic
   state_t state_reg;
   state_t state_next;
   logic [DATA_W-1:0] accum_reg;
   logic [DATA_W-1:0] accum_next;
   logic carry_reg;
   logic carry_next;
   logic dc_reg;
   logic dc_next;
   logic zero_reg;
   logic zero_next;
   logic we_reg;
   logic we_next;
   logic [ADDR_W-1:0] waddr_reg;
   logic [ADDR_W-1:0] waddr_next;
   logic [DATA_W-1:0] wdata_reg;
   logic [DATA_W-1:0] wdata_next;
   logic pclr_reg;
   logic pclr_next;

   logic issue;
   logic [DATA_W-1:0] file_val;
   logic [DATA_W-1:0] add_rhs;
   logic [DATA_W:0] sum;
   logic [NIBBLE_W:0] nibble_sum;
   logic [DATA_W-1:0] bit_mask;
   logic test_bit;

   // an instruction is only taken while not in the discarded slot
   assign OP_READY = (state_reg == ST_EXEC);
   assign issue = OP_VALID && OP_READY;

   // port reads take the pin levels, since a latch may disagree with an input pin
   assign file_val = FILE_IS_PORT ? pin_sync_reg : FILE_RDATA;
   assign add_rhs = (OP_CODE == add_immediate_to_accum) ? OP_IMM : file_val;
   assign sum = {1'b0, accum_reg} + {1'b0, add_rhs};
   assign nibble_sum = {1'b0, accum_reg[NIBBLE_W-1:0]} + {1'b0, add_rhs[NIBBLE_W-1:0]};
   assign bit_mask = BIT_ONE << OP_BIT_SEL;
   assign test_bit = file_val[OP_BIT_SEL];

   ////////////////////////////////////////////////////////////////////////////
   // next-state computation for the whole execute stage
   always_comb begin
      state_next = ST_EXEC;
      accum_next = accum_reg;
      carry_next = carry_reg;
      dc_next = dc_reg;
      zero_next = zero_reg;
      we_next = 1'b0;
      waddr_next = waddr_reg;
      wdata_next = wdata_reg;
      pclr_next = 1'b0;
      if (issue) begin
         waddr_next = OP_FILE_ADDR;
         case (OP_CODE)
            add_immediate_to_accum: begin
               accum_next = sum[DATA_W-1:0];
               carry_next = sum[DATA_W];
               dc_next = nibble_sum[NIBBLE_W];
               zero_next = (sum[DATA_W-1:0] == ACCUM_RST);
            end
            add_accum_with_file: begin
               carry_next = sum[DATA_W];
               dc_next = nibble_sum[NIBBLE_W];
               zero_next = (sum[DATA_W-1:0] == ACCUM_RST);
               if (OP_DEST == DEST_ACCUM) begin
                  accum_next = sum[DATA_W-1:0];
               end else begin
                  we_next = 1'b1;
                  wdata_next = sum[DATA_W-1:0];
               end
            end
            and_immediate_into_accum: begin
               accum_next = accum_reg & OP_IMM;
               zero_next = ((accum_reg & OP_IMM) == ACCUM_RST);
            end
            and_accum_with_file: begin
               zero_next = ((accum_reg & file_val) == ACCUM_RST);
               if (OP_DEST == DEST_ACCUM) begin
                  accum_next = accum_reg & file_val;
               end else begin
                  we_next = 1'b1;
                  wdata_next = accum_reg & file_val;
               end
            end
            file_bit_clear: begin
               we_next = 1'b1;
               wdata_next = file_val & ~bit_mask;
            end
            file_bit_set: begin
               we_next = 1'b1;
               wdata_next = file_val | bit_mask;
            end
            test_skip_if_zero_bit: begin
               // flags and registers stay; only the slot after is discarded
               state_next = test_bit ? ST_EXEC : ST_SKIP;
            end
            test_skip_if_one_bit: begin
               state_next = test_bit ? ST_SKIP : ST_EXEC;
            end
            default: begin
               state_next = ST_EXEC;
            end
         endcase
         // any write back onto the timer counter restarts the prescaler while PRESCALER_ON_TIMER is set
         pclr_next = we_next && FILE_IS_TIMER && PRESCALER_ON_TIMER;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_EXEC;
         accum_reg <= ACCUM_RST;
         carry_reg <= FLAG_RST;
         dc_reg <= FLAG_RST;
         zero_reg <= FLAG_RST;
         we_reg <= 1'b0;
         waddr_reg <= ADDR_RST;
         wdata_reg <= ACCUM_RST;
         pclr_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         accum_reg <= accum_next;
         carry_reg <= carry_next;
         dc_reg <= dc_next;
         zero_reg <= zero_next;
         we_reg <= we_next;
         waddr_reg <= waddr_next;
         wdata_reg <= wdata_next;
         pclr_reg <= pclr_next;
      end
   end

   // all data outputs straight from flops
   assign ACCUM = accum_reg;
   assign CARRY = carry_reg;
   assign NIBBLE_CARRY = dc_reg;
   assign ZERO = zero_reg;
   assign FILE_WE = we_reg;
   assign FILE_WADDR = waddr_reg;
   assign FILE_WDATA = wdata_reg;
   assign SKIPPING = (state_reg == ST_SKIP);
   assign PRESCALER_CLR = pclr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_add_imm;
      @(posedge CLK) disable iff (!rst_n)
      (issue && OP_CODE == add_immediate_to_accum)
      |=> (ACCUM == 8'($past(accum_reg) + $past(OP_IMM))) && !FILE_WE;
   endproperty
   a_add_imm: assert property (p_add_imm) else $error("add immediate result wrong");

   property p_add_file_flags;
      @(posedge CLK) disable iff (!rst_n)
      (issue && OP_CODE == add_accum_with_file)
      |=> (CARRY == (({1'b0, $past(accum_reg)} + {1'b0, $past(file_val)}) > 9'h0ff))
          && (NIBBLE_CARRY == (({1'b0, $past(accum_reg[3:0])} + {1'b0, $past(file_val[3:0])}) > 5'h0f))
          && (ZERO == (8'($past(accum_reg) + $past(file_val)) == 8'h00));
   endproperty
   a_add_file_flags: assert property (p_add_file_flags) else $error("add with file flags wrong");

   property p_dest_sel;
      @(posedge CLK) disable iff (!rst_n)
      (issue && (OP_CODE == add_accum_with_file || OP_CODE == and_accum_with_file))
      |=> (FILE_WE == $past(OP_DEST)) && (FILE_WE ? $stable(ACCUM) : $stable(FILE_WDATA));
   endproperty
   a_dest_sel: assert property (p_dest_sel) else $error("destination select not honoured");

   property p_bit_clear;
      @(posedge CLK) disable iff (!rst_n)
      (issue && OP_CODE == file_bit_clear)
      |=> FILE_WE && (FILE_WDATA == ($past(file_val) & ~(8'h01 << $past(OP_BIT_SEL))))
          && $stable(CARRY) && $stable(NIBBLE_CARRY) && $stable(ZERO);
   endproperty
   a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");

   property p_bit_set;
      @(posedge CLK) disable iff (!rst_n)
      (issue && OP_CODE == file_bit_set)
      |=> FILE_WE && (FILE_WDATA == ($past(file_val) | (8'h01 << $past(OP_BIT_SEL))))
          && $stable(ZERO) && $stable(ACCUM);
   endproperty
   a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

   property p_and_imm;
      @(posedge CLK) disable iff (!rst_n)
      (issue && OP_CODE == and_immediate_into_accum)
      |=> (ACCUM == ($past(accum_reg) & $past(OP_IMM))) && $stable(CARRY) && $stable(NIBBLE_CARRY);
   endproperty
   a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");

   property p_and_file;
      @(posedge CLK) disable iff (!rst_n)
      (issue && OP_CODE == and_accum_with_file && OP_DEST == 1'b1)
      |=> (FILE_WDATA == ($past(accum_reg) & $past(file_val))) && $stable(CARRY) && $stable(ACCUM);
   endproperty
   a_and_file: assert property (p_and_file) else $error("and with file wrong");

   property p_skip_zero;
      @(posedge CLK) disable iff (!rst_n)
      (issue && OP_CODE == test_skip_if_zero_bit && !test_bit)
      |=> SKIPPING && !OP_READY ##1 !SKIPPING && !FILE_WE;
   endproperty
   a_skip_zero: assert property (p_skip_zero) else $error("skip if zero did not skip once");

   property p_no_skip;
      @(posedge CLK) disable iff (!rst_n)
      (issue && ((OP_CODE == test_skip_if_zero_bit && test_bit) || (OP_CODE == test_skip_if_one_bit && !test_bit)))
      |=> !SKIPPING && OP_READY;
   endproperty
   a_no_skip: assert property (p_no_skip) else $error("false test skipped");

   property p_skip_one;
      @(posedge CLK) disable iff (!rst_n)
      (issue && OP_CODE == test_skip_if_one_bit && test_bit)
      |=> (SKIPPING && $stable(CARRY) && $stable(NIBBLE_CARRY) && $stable(ZERO) && $stable(ACCUM)) [*1]
          ##1 (!SKIPPING && $stable(ZERO) && $stable(ACCUM) && !FILE_WE);
   endproperty
   a_skip_one: assert property (p_skip_one) else $error("skip if one wrong or flags moved");

   property p_port_read;
      @(posedge CLK) disable iff (!rst_n)
      (issue && FILE_IS_PORT && OP_CODE == file_bit_set)
      |=> FILE_WDATA == ($past(pin_sync_reg) | (8'h01 << $past(OP_BIT_SEL)));
   endproperty
   a_port_read: assert property (p_port_read) else $error("port write-back not from pins");

   property p_prescaler;
      @(posedge CLK) disable iff (!rst_n)
      PRESCALER_CLR == (FILE_WE && $past(issue) && $past(FILE_IS_TIMER) && $past(PRESCALER_ON_TIMER));
   endproperty
   a_prescaler: assert property (p_prescaler) else $error("prescaler clear mismatch");

   property p_add_imm_flags;
      @(posedge CLK) disable iff (!rst_n)
      (issue && OP_CODE == add_immediate_to_accum)
      |=> (CARRY == (({1'b0, $past(accum_reg)} + {1'b0, $past(OP_IMM)}) > 9'h0ff))
          && (NIBBLE_CARRY == (({1'b0, $past(accum_reg[3:0])} + {1'b0, $past(OP_IMM[3:0])}) > 5'h0f))
          && (ZERO == (ACCUM == 8'h00));
   endproperty
   a_add_imm_flags: assert property (p_add_imm_flags) else $error("add flags wrong");

endmodule

`default_nettype wire

// ===== alu_bit_ops_exec_tb_top.sv
// alu_bit_ops_exec_tb_top: self-checking bench for the add / and / bit execute stage.
// assumes the package is compiled first; the bench plays decoder, register file,
// pins and timer itself and keeps its own model of accumulator and flags.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) \
   checks_done++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
   end

module alu_bit_ops_exec_tb_top
   import alu_bit_ops_pkg::*;
;
   typedef struct {
      logic [7:0] acc;
      logic c, dc, z, we;
      logic [6:0] addr;
      logic [7:0] wdata;
      logic skip, pclr;
   } note_t;

   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic op_valid = 1'b0;
   op_t op_code = add_immediate_to_accum;
   logic [7:0] op_imm = 8'h00;
   logic [6:0] op_addr = 7'h00;
   logic [2:0] op_bit = 3'h0;
   logic op_dest = 1'b0;
   logic [7:0] file_rdata = 8'h00;
   logic file_is_port = 1'b0;
   logic [7:0] pin_levels = 8'h00;
   logic file_is_timer = 1'b0;
   logic pre_on_timer = 1'b0;
   logic op_ready, file_we, carry, nibble_carry, zero, skipping, prescaler_clr;
   logic [6:0] file_waddr;
   logic [7:0] file_wdata, accum;
   logic taken = 1'b0;
   int bad_count = 0;
   int checks_done = 0;
   note_t note_q[$];
   note_t ex;
   // model state: accumulator, flags and the pin value the stage sees after sync
   logic [7:0] m_acc = 8'h00;
   logic [7:0] m_pins = 8'h00;
   logic m_c = 1'b0;
   logic m_dc = 1'b0;
   logic m_z = 1'b0;

   // 125 MHz core clock
   always #4 clk = ~clk;

   alu_bit_ops_exec dut_u (.CLK(clk), .RESETN(rst_n), .OP_VALID(op_valid), .OP_READY(op_ready),
      .OP_CODE(op_code), .OP_IMM(op_imm), .OP_FILE_ADDR(op_addr), .OP_BIT_SEL(op_bit), .OP_DEST(op_dest),
      .FILE_RDATA(file_rdata), .FILE_IS_PORT(file_is_port), .PIN_LEVELS(pin_levels),
      .FILE_IS_TIMER(file_is_timer), .PRESCALER_ON_TIMER(pre_on_timer), .FILE_WE(file_we),
      .FILE_WADDR(file_waddr), .FILE_WDATA(file_wdata), .ACCUM(accum), .CARRY(carry),
      .NIBBLE_CARRY(nibble_carry), .ZERO(zero), .SKIPPING(skipping), .PRESCALER_CLR(prescaler_clr));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // present one instruction; keep=0 marks the slot a true skip must discard
   task automatic present(input op_t op, input logic [7:0] imm, input logic [6:0] adr, input logic [2:0] bs,
                          input logic d, input logic [7:0] rd, input logic prt, input logic tmr,
                          input logic pre, input logic keep, output logic skip);
      note_t n;
      logic [8:0] s;
      logic [7:0] b, r;
      logic we;
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= op;
      op_imm <= imm;
      op_addr <= adr;
      op_bit <= bs;
      op_dest <= d;
      file_rdata <= rd;
      file_is_port <= prt;
      file_is_timer <= tmr;
      pre_on_timer <= pre;
      skip = 1'b0;
      if (keep) begin
         // port registers are read from the pins, so rd is deliberately different
         b = prt ? m_pins : rd;
         r = b;
         case (op)
            add_immediate_to_accum, add_accum_with_file: begin
               if (op == add_immediate_to_accum) b = imm;
               s = {1'b0, m_acc} + {1'b0, b};
               m_c = s[8];
               m_dc = 1'(({1'b0, m_acc[3:0]} + {1'b0, b[3:0]}) >> 4);
               r = s[7:0];
               m_z = (r == 8'h00);
            end
            and_immediate_into_accum, and_accum_with_file: begin
               r = m_acc & ((op == and_immediate_into_accum) ? imm : b);
               m_z = (r == 8'h00);
            end
            file_bit_clear: r = b & ~(BIT_ONE << bs);
            file_bit_set: r = b | (BIT_ONE << bs);
            default: skip = (b[bs] == (op == test_skip_if_one_bit));
         endcase
         we = (op == file_bit_clear) || (op == file_bit_set) ||
              (((op == add_accum_with_file) || (op == and_accum_with_file)) && d);
         if (op inside {add_immediate_to_accum, add_accum_with_file, and_immediate_into_accum,
                        and_accum_with_file} && !we) m_acc = r;
         n = '{m_acc, m_c, m_dc, m_z, we, adr, r, skip, we & tmr & pre};
         note_q.push_back(n);
      end
   endtask

   // change the pins with the port idle long enough for the synchroniser
   task automatic set_pins(input logic [7:0] v);
      @(posedge clk);
      op_valid <= 1'b0;
      pin_levels <= v;
      m_pins = v;
      repeat (3) @(posedge clk);
   endtask

   task automatic drain(input string nm);
      int i;
      @(posedge clk);
      op_valid <= 1'b0;
      for (i = 0; i < 10 && note_q.size() > 0; i++) @(posedge clk);
      // a result that never shows ends the run at once
      if (note_q.size() > 0) begin
         bad_count++;
         $display("CHECK FAILED pending results expected 0 seen %0d", note_q.size());
         give_verdict();
      end else begin
         $display("test %s done", nm);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // monitor: a taken edge means a result shows in the cycle after it
   always @(posedge clk) taken <= op_valid && op_ready;

   always @(negedge clk) begin
      if (taken === 1'b1) begin
         if (note_q.size() == 0) begin
            bad_count++;
            $display("CHECK FAILED note queue expected 1 seen 0");
         end else begin
            ex = note_q.pop_front();
            `CHK("ACCUM", ex.acc, accum)
            `CHK("CARRY", ex.c, carry)
            `CHK("NIBBLE_CARRY", ex.dc, nibble_carry)
            `CHK("ZERO", ex.z, zero)
            `CHK("FILE_WE", ex.we, file_we)
            `CHK("FILE_WADDR", ex.addr, file_waddr)
            if (ex.we) begin
               `CHK("FILE_WDATA", ex.wdata, file_wdata)
            end
            `CHK("SKIPPING", ex.skip, skipping)
            `CHK("OP_READY", !ex.skip, op_ready)
            `CHK("PRESCALER_CLR", ex.pclr, prescaler_clr)
         end
      end else begin
         // idle or discarded slot: nothing may be written
         `CHK("FILE_WE idle", 1'b0, file_we)
         `CHK("SKIPPING idle", 1'b0, skipping)
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // hang guard: the run is far shorter than this
   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      $display("CHECK FAILED run length expected end seen timeout");
      give_verdict();
   end

   initial begin
      logic sk;
      logic [31:0] rv, rw;
      int blk, k;
      repeat (10) @(posedge clk);
      `CHK("ACCUM reset", 8'h00, accum)
      `CHK("OP_READY reset", 1'b1, op_ready)
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      void'($urandom(32'hdd61));
      // nibble carry alone, then carry with zero result
      present(add_immediate_to_accum, 8'h0f, 7'h00, 3'h0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1, sk);
      present(add_immediate_to_accum, 8'h01, 7'h00, 3'h0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1, sk);
      present(add_immediate_to_accum, 8'hf0, 7'h00, 3'h0, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b1, sk);
      // both skip tests with the bit set and clear; a discarded slot follows each true skip
      for (k = 0; k < 4; k++) begin
         present(op_t'(k[1] ? test_skip_if_zero_bit : test_skip_if_one_bit), 8'h00, 7'h05, {2'b00, k[0]}, 1'b0,
                 8'h02, 1'b0, 1'b0, 1'b0, 1'b1, sk);
         if (sk) present(add_immediate_to_accum, 8'h55, 7'h7f, 3'h7, 1'b1, 8'h33, 1'b0, 1'b1, 1'b1, 1'b0, sk);
      end
      drain("directed");
      // random back-to-back instructions over all codes, ports and timer settings
      for (blk = 0; blk < 8; blk++) begin
         rv = $urandom;
         set_pins(rv[7:0]);
         for (k = 0; k < 40; k++) begin
            rv = $urandom;
            rw = $urandom;
            present(op_t'(rv[2:0]), rv[10:3], rv[17:11], rv[20:18], rv[21], rv[29:22], rv[30], rv[31],
                    rw[0], 1'b1, sk);
            if (sk) present(op_t'(rw[3:1]), rw[11:4], rw[18:12], rw[21:19], 1'b1, rw[29:22], 1'b0, 1'b1,
                            1'b1, 1'b0, sk);
         end
         drain("random block");
      end
      give_verdict();
   end
endmodule
`default_nettype wire
